/* hw/e1ro_status_bank.sv */
// Functional notes
// - Bit 7 of non-alignment word holds first overhead bit of non-alignment frame.
// - Bit 6 holds second non-alignment bit, expected one.
// - Bit 5 holds remote alarm A bit, one means alarm.
// - Bits 4..0 hold national-use bits four to eight.
// - Bits 7..4 of multiframe word hold timeslot 16 bits one to four, frame zero.
// - Bit 3 holds timeslot 16 bit five, first spare bit.
// - Bit 2 holds timeslot 16 bit six, remote multiframe loss.
// - Bits 1..0 hold timeslot 16 bits seven and eight, spare bits.
// - Slip bit 7 inverts on every controlled receive slip.
// - Bit 6 records slip direction: one repeated frame, zero lost frame.
// - Bit 5 high after 512 alternating bits, tolerating sparse errors.
// - Bit 4 high when both latest alignment words were errored.
// - Eighth-bit phase count bits 11..8 shown in bits 3..0.
// - Phase count bits 7..0 shown in the low phase word.
// - Dejitter bit 7 high while clock period lengthened.
// - Dejitter bit 6 high while clock period shortened.
// - Dejitter bit 5 flags FIFO empty, bit 1 FIFO full.
// - Dejitter bit 4 flags at least four used locations.
// - Dejitter bit 3 flags FIFO at least half full.
// - Dejitter bit 2 flags at most four free locations.
module e1ro_status_bank
    import e1ro_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire e1ro_ts0_s  ts0,
    input  wire e1ro_ts16_s ts16,
    input  wire logic       rxBit,
    input  wire logic       rxBitValid,
    input  wire logic       slipEvent,
    input  wire logic       slipRepeat,
    input  wire logic       eighthTick,
    input  wire logic       bpFramePulse,
    input  wire logic       receive_frame_pulse,
    input  wire e1ro_ja_s   ja,
    input  wire logic [4:0] regAddr,
    input  wire logic       regRd,
    output logic [7:0]      regRdData
);

    logic [7:0]         nonAlign;
    logic [7:0]         mfAlign;
    logic               slip_toggle;
    logic               slip_direction;
    logic [1:0]         fasErrHist;
    logic [PHASE_W-1:0] phaseRun;
    logic [PHASE_W-1:0] phase_eighth_bit_count;
    logic [7:0]         jaFlags;

    logic [7:0]         next_nonAlign;
    logic [7:0]         next_mfAlign;
    logic               next_slip_toggle;
    logic               next_slip_direction;
    logic [1:0]         next_fasErrHist;
    logic [PHASE_W-1:0] next_phaseRun;
    logic [PHASE_W-1:0] next_phase_eighth_bit_count;
    logic [7:0]         next_jaFlags;
    logic [7:0]         next_regRdData;

    logic               alternating_pattern_detect;
    logic               consecutive_fas_errors;
    logic [7:0]         slipWord;

    e1ro_aux_detect u_aux (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .rxBit      (rxBit),
        .rxBitValid (rxBitValid),
        .detected   (alternating_pattern_detect)
    );

    // Overhead capture
    always_comb begin
        next_nonAlign   = nonAlign;
        next_mfAlign    = mfAlign;
        next_fasErrHist = fasErrHist;
        if (ts0.valid) begin
            if (ts0.isFas) begin
                next_fasErrHist = {fasErrHist[0], (ts0.data[6:0] != FAS_PATTERN)};
            end else begin
                next_nonAlign = ts0.data;
            end
        end
        if (ts16.valid && ts16.frameZero) begin
            next_mfAlign = ts16.data;
        end
    end

    assign consecutive_fas_errors = &fasErrHist;

    // Slip tracking
    always_comb begin
        next_slip_toggle    = slip_toggle;
        next_slip_direction = slip_direction;
        if (slipEvent) begin
            next_slip_toggle    = ~slip_toggle;
            next_slip_direction = slipRepeat;
        end
    end

    // Phase measurement, backplane pulse restarts the run
    always_comb begin
        next_phaseRun               = phaseRun;
        next_phase_eighth_bit_count = phase_eighth_bit_count;
        if (bpFramePulse) begin
            next_phaseRun = PHASE_RESET;
        end else if (eighthTick) begin
            next_phaseRun = phaseRun + PHASE_ONE;
        end
        if (receive_frame_pulse) begin
            next_phase_eighth_bit_count = phaseRun;
        end
    end

    always_comb begin
        next_jaFlags = e1ro_ja_flags(ja);
    end

    // high phase bits beside slip and pattern flags
    assign slipWord = {slip_toggle, slip_direction, alternating_pattern_detect,
                       consecutive_fas_errors, phase_eighth_bit_count[11:8]};

    always_comb begin
        next_regRdData = regRdData;
        if (regRd) begin
            if (regAddr == ADDR_NON_ALIGN) begin
                next_regRdData = nonAlign;
            end else if (regAddr == ADDR_MF_ALIGN) begin
                next_regRdData = mfAlign;
            end else if (regAddr == ADDR_SLIP_HIGH) begin
                next_regRdData = slipWord;
            end else if (regAddr == ADDR_PHASE_LOW) begin
                next_regRdData = phase_eighth_bit_count[7:0];
            end else if (regAddr == ADDR_JA_STATUS) begin
                next_regRdData = jaFlags;
            end else begin
                next_regRdData = UNMAPPED_READ;
            end
        end
    end

    // Overhead words and alignment error history
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            nonAlign   <= REG_RESET;
            mfAlign    <= REG_RESET;
            fasErrHist <= 2'h0;
        end else begin
            nonAlign   <= next_nonAlign;
            mfAlign    <= next_mfAlign;
            fasErrHist <= next_fasErrHist;
        end
    end

    // Slip state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            slip_toggle    <= 1'h0;
            slip_direction <= 1'h0;
        end else begin
            slip_toggle    <= next_slip_toggle;
            slip_direction <= next_slip_direction;
        end
    end

    // Phase run and captured offset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phaseRun               <= PHASE_RESET;
            phase_eighth_bit_count <= PHASE_RESET;
        end else begin
            phaseRun               <= next_phaseRun;
            phase_eighth_bit_count <= next_phase_eighth_bit_count;
        end
    end

    // Dejitter flags, one stage behind the FIFO levels
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            jaFlags <= REG_RESET;
        end else begin
            jaFlags <= next_jaFlags;
        end
    end

    // Read data holds between reads
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= REG_RESET;
        end else begin
            regRdData <= next_regRdData;
        end
    end

endmodule

/* hw/e1ro_pkg.sv */
package e1ro_pkg;

    // Register offsets on the status page
    localparam logic [4:0] ADDR_NON_ALIGN = 5'h13;
    localparam logic [4:0] ADDR_MF_ALIGN  = 5'h14;
    localparam logic [4:0] ADDR_SLIP_HIGH = 5'h15;
    localparam logic [4:0] ADDR_PHASE_LOW = 5'h16;
    localparam logic [4:0] ADDR_JA_STATUS = 5'h17;

    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Expected frame alignment pattern in overhead bits 2..8
    localparam logic [6:0] FAS_PATTERN = 7'h1B;

    // Phase count
    localparam int         PHASE_W      = 12;
    localparam logic [11:0] PHASE_RESET = 12'h000;
    localparam logic [11:0] PHASE_ONE   = 12'h001;

    // Alternating pattern detector
    localparam logic [8:0] AUX_WINDOW_LAST = 9'h1FF;
    localparam logic [8:0] AUX_COUNT_ONE   = 9'h001;
    localparam logic [8:0] AUX_COUNT_ZERO  = 9'h000;
    localparam logic [3:0] AUX_ERR_MAX     = 4'h4;
    localparam logic [3:0] AUX_ERR_ONE     = 4'h1;
    localparam logic [3:0] AUX_ERR_ZERO    = 4'h0;

    // Dejitter FIFO geometry
    localparam int         JA_FILL_W   = 6;
    localparam logic [5:0] JA_DEPTH    = 6'h20;
    localparam logic [5:0] JA_HALF     = 6'h10;
    localparam logic [5:0] JA_FOUR     = 6'h04;
    localparam logic [5:0] JA_EMPTY    = 6'h00;

    typedef struct packed {
        logic       valid;
        logic       isFas;
        logic [7:0] data;
    } e1ro_ts0_s;

    typedef struct packed {
        logic       valid;
        logic       frameZero;
        logic [7:0] data;
    } e1ro_ts16_s;

    typedef struct packed {
        logic                 slow;
        logic                 fast;
        logic [JA_FILL_W-1:0] fill;
    } e1ro_ja_s;

    function automatic logic [7:0] e1ro_ja_flags(input e1ro_ja_s ja);
        logic [7:0] f;
        f    = 8'h00;
        f[7] = ja.slow;
        f[6] = ja.fast;
        f[5] = (ja.fill == JA_EMPTY);
        f[4] = (ja.fill >= JA_FOUR);
        f[3] = (ja.fill >= JA_HALF);
        f[2] = ((JA_DEPTH - ja.fill) <= JA_FOUR);
        f[1] = (ja.fill == JA_DEPTH);
        return f;
    endfunction

endpackage

/* hw/e1ro_aux_detect.sv */
module e1ro_aux_detect
    import e1ro_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic rxBit,
    input  wire logic rxBitValid,
    output logic      detected
);

    logic [8:0] bitCount;
    logic [3:0] errCount;
    logic       expectBit;
    logic [8:0] next_bitCount;
    logic [3:0] next_errCount;
    logic       next_expectBit;
    logic       next_detected;
    logic       mismatch;

    // Windowed error budget keeps detection alive under sparse bit errors
    always_comb begin
        next_bitCount  = bitCount;
        next_errCount  = errCount;
        next_expectBit = expectBit;
        next_detected  = detected;
        mismatch       = (rxBit != expectBit);
        if (rxBitValid) begin
            next_bitCount = bitCount + AUX_COUNT_ONE;
            if (bitCount == AUX_COUNT_ZERO) begin
                // First bit of a window sets the phase
                next_expectBit = ~rxBit;
                next_errCount  = AUX_ERR_ZERO;
            end else begin
                next_expectBit = ~expectBit;
                if (mismatch && errCount != AUX_ERR_MAX + AUX_ERR_ONE) begin
                    next_errCount = errCount + AUX_ERR_ONE;
                end
                if (bitCount == AUX_WINDOW_LAST) begin
                    next_detected = ((mismatch ? errCount + AUX_ERR_ONE : errCount) <= AUX_ERR_MAX);
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bitCount  <= AUX_COUNT_ZERO;
            errCount  <= AUX_ERR_ZERO;
            expectBit <= 1'b0;
            detected  <= 1'b0;
        end else begin
            bitCount  <= next_bitCount;
            errCount  <= next_errCount;
            expectBit <= next_expectBit;
            detected  <= next_detected;
        end
    end

endmodule

/* verif/e1ro_sva.sv */
module e1ro_sva
    import e1ro_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire e1ro_ts0_s  ts0,
    input wire e1ro_ts16_s ts16,
    input wire logic       slipEvent,
    input wire logic       slipRepeat,
    input wire e1ro_ja_s   ja,
    input wire logic [4:0] regAddr,
    input wire logic       regRd,
    input wire logic [7:0] regRdData
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Flag word lags ja by one stage, so skip reads right out of reset
    wire jaRd = regRd && regAddr == ADDR_JA_STATUS;
    chk_nfas_capture: assert property (ts0.valid && !ts0.isFas ##1 regRd && regAddr == ADDR_NON_ALIGN
        |=> regRdData == $past(ts0.data, 2)) else $error("nfas byte lost");
    chk_mf_capture: assert property (ts16.valid && ts16.frameZero ##1 regRd && regAddr == ADDR_MF_ALIGN
        |=> regRdData == $past(ts16.data, 2)) else $error("mf byte lost");
    chk_slip_direction: assert property (slipEvent ##1 regRd && regAddr == ADDR_SLIP_HIGH
        |=> regRdData[6] == $past(slipRepeat, 2)) else $error("slip direction");
    chk_read_hold: assert property (!regRd |=> $stable(regRdData)) else $error("read data moved");
    chk_unmapped_zero: assert property (regRd && (regAddr < ADDR_NON_ALIGN || regAddr > ADDR_JA_STATUS)
        |=> regRdData == UNMAPPED_READ) else $error("unmapped read");
    chk_ja_clock: assert property ($past(rst_b) && jaRd
        |=> regRdData[7:6] == {$past(ja.slow, 2), $past(ja.fast, 2)}) else $error("clock flags");
    chk_ja_empty: assert property ($past(rst_b) && jaRd
        |=> regRdData[5] == ($past(ja.fill, 2) == 6'h00)) else $error("empty flag");
    chk_ja_full: assert property ($past(rst_b) && jaRd
        |=> regRdData[1] == ($past(ja.fill, 2) == 6'h20)) else $error("full flag");
    cover property (ts16.valid && ts16.frameZero ##1 regRd);
    cover property (slipEvent ##1 regRd);
    cover property (jaRd && ja.fill == 6'h20);
endmodule

/* verif/e1ro_line_model.sv */
module e1ro_line_model
    import e1ro_pkg::*;
(
    input  wire logic  ref_clk,
    output e1ro_ts0_s  ts0,
    output e1ro_ts16_s ts16,
    output logic       rxBit,
    output logic       rxBitValid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic altPhase = 1'b1;
    initial begin
        ts0 = '0;
        ts16 = '0;
        rxBit = 1'b0;
        rxBitValid = 1'b0;
    end
    // Released lanes carry inverted junk, never the last byte
    task automatic send_ts0(input logic fas, input logic [7:0] d);
        ts0 <= '{1'b1, fas, d};
        @(posedge ref_clk);
        ts0 <= '{1'b0, ~fas, ~d};
    endtask
    task automatic send_ts16(input logic fz, input logic [7:0] d);
        ts16 <= '{1'b1, fz, d};
        @(posedge ref_clk);
        ts16 <= '{1'b0, ~fz, ~d};
    endtask
    // One 512-bit window, nErr bits flipped from bit 100
    task automatic send_alt(input int nErr);
        for (int i = 0; i < 512; i++) begin
            rxBitValid <= 1'b1;
            rxBit <= altPhase ^ (i >= 100 && i < 100 + nErr);
            altPhase = ~altPhase;
            @(posedge ref_clk);
        end
        rxBitValid <= 1'b0;
        rxBit <= altPhase;
        @(posedge ref_clk);
    endtask
endmodule

/* verif/e1ro_status_bank_tb.sv */
module e1ro_status_bank_tb
    import e1ro_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       ref_clk = 1'b0, rst_b = 1'b0, regRd = 1'b0;
    logic       slipEvent = 1'b0, slipRepeat = 1'b0, eighthTick = 1'b0;
    logic       bpFramePulse = 1'b0, rxFramePulse = 1'b0, rxBit, rxBitValid;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regRdData, v;
    e1ro_ts0_s  ts0;
    e1ro_ts16_s ts16;
    e1ro_ja_s   ja = '0;
    int         failures = 0, n_compared = 0;
    e1ro_line_model model_u (.ref_clk, .ts0, .ts16, .rxBit, .rxBitValid);
    e1ro_status_bank dut_u (.ref_clk, .rst_b, .ts0, .ts16, .rxBit, .rxBitValid, .slipEvent, .slipRepeat,
        .eighthTick, .bpFramePulse, .receive_frame_pulse(rxFramePulse), .ja, .regAddr, .regRd, .regRdData);
    initial forever #50 ref_clk = ~ref_clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Entered and left at a rising edge
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(posedge ref_clk);
        d = regRdData;
    endtask
    task automatic test_done;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic t_unmapped;
        logic [4:0] bad [4] = '{5'h00, 5'h12, 5'h18, 5'h1F};
        // A nonzero word read first exposes a decode that holds stale data
        foreach (bad[i]) begin
            rd(ADDR_NON_ALIGN, v);
            check(v, 8'h5A);
            rd(bad[i], v);
            check(v, UNMAPPED_READ);
        end
        $display("t_unmapped end");
    endtask
    task automatic t_overhead;
        model_u.send_ts0(1'b0, 8'hA5);
        rd(ADDR_NON_ALIGN, v);
        check(v, 8'hA5);
        model_u.send_ts0(1'b1, 8'h5A);
        model_u.send_ts16(1'b1, 8'h96);
        rd(ADDR_MF_ALIGN, v);
        check(v, 8'h96);
        model_u.send_ts16(1'b0, 8'h0F);
        rd(ADDR_MF_ALIGN, v);
        check(v, 8'h96);
        rd(ADDR_NON_ALIGN, v);
        check(v, 8'hA5);
        model_u.send_ts0(1'b0, 8'h5A);
        rd(ADDR_NON_ALIGN, v);
        rd(ADDR_NON_ALIGN, v);
        check(v, 8'h5A);
        $display("t_overhead end");
    endtask
    task automatic t_fas;
        logic [7:0] fasByte [4] = '{8'h00, 8'h9B, 8'h00, 8'h7F};
        logic [7:0] flag [4] = '{8'h10, 8'h00, 8'h00, 8'h10};
        foreach (fasByte[i]) begin
            model_u.send_ts0(1'b1, fasByte[i]);
            rd(ADDR_SLIP_HIGH, v);
            check(v & 8'h10, flag[i]);
        end
        $display("t_fas end");
    endtask
    // Mid-run reset clears captured words and error history
    task automatic t_reset;
        rst_b <= 1'b0;
        @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(ADDR_NON_ALIGN, v);
        check(v, REG_RESET);
        rd(ADDR_SLIP_HIGH, v);
        check(v, REG_RESET);
        $display("t_reset end");
    endtask
    task automatic t_slip;
        for (int i = 0; i < 2; i++) begin
            slipEvent <= 1'b1;
            slipRepeat <= ~i[0];
            @(posedge ref_clk);
            slipEvent <= 1'b0;
            rd(ADDR_SLIP_HIGH, v);
            check(v & 8'hC0, i[0] ? 8'h00 : 8'hC0);
        end
        $display("t_slip end");
    endtask
    // Clear and tick together: clear must win, else count is one high
    task automatic t_phase;
        bpFramePulse <= 1'b1;
        eighthTick <= 1'b1;
        @(posedge ref_clk);
        bpFramePulse <= 1'b0;
        repeat (291) @(posedge ref_clk);
        eighthTick <= 1'b0;
        rxFramePulse <= 1'b1;
        @(posedge ref_clk);
        rxFramePulse <= 1'b0;
        rd(ADDR_SLIP_HIGH, v);
        check(v & 8'h0F, 8'h01);
        rd(ADDR_PHASE_LOW, v);
        check(v, 8'h23);
        $display("t_phase end");
    endtask
    task automatic t_aux;
        model_u.send_alt(4);
        rd(ADDR_SLIP_HIGH, v);
        check(v & 8'h20, 8'h20);
        model_u.send_alt(5);
        rd(ADDR_SLIP_HIGH, v);
        check(v & 8'h20, 8'h00);
        $display("t_aux end");
    endtask
    task automatic t_ja;
        logic [5:0] f [8] = '{6'h00, 6'h03, 6'h04, 6'h0F, 6'h10, 6'h1B, 6'h1C, 6'h20};
        foreach (f[i]) begin
            ja <= '{i[0], i[1], f[i]};
            @(posedge ref_clk);
            rd(ADDR_JA_STATUS, v);
            check(v, {i[0], i[1], f[i] == 6'h00, f[i] >= 6'h04, f[i] >= 6'h10, f[i] >= 6'h1C, f[i] == 6'h20, 1'b0});
        end
        $display("t_ja end");
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_overhead();
        t_unmapped();
        t_fas();
        t_reset();
        t_slip();
        t_phase();
        t_aux();
        t_ja();
        test_done();
    end
    // About three and a half times the expected run
    initial begin
        #500000;
        failures++;
        test_done();
    end
endmodule
bind e1ro_status_bank e1ro_sva chk_u (.ref_clk, .rst_b, .ts0, .ts16, .slipEvent, .slipRepeat, .ja,
    .regAddr, .regRd, .regRdData);
